/* ppc_periph_model.sv */
// peripheral block model: drives the peripheral outputs toward the crossbar
`timescale 1ns/1ps
module ppc_periph_model (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    // peripheral outputs: txd pwm1 pwm0 scl sda tdo sdo mosi sck
    output logic      [8:0] periph_out
);
    logic [8:0] lfsr_q;
    logic [8:0] lfsr_d;

    ////////////////////////////////////////////////////////////////////////////
    // pattern changes every cycle so a stale value never passes for a match
    assign lfsr_d = {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};

    // pattern register, updated just after each rising edge
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            lfsr_q <= 9'h1a5;
        end else begin
            lfsr_q <= lfsr_d;
        end
    end

    // uart line mostly idles high, low one cycle in four
    assign periph_out = {lfsr_q[8] | lfsr_q[2], lfsr_q[7:0]};
endmodule : ppc_periph_model

/* ppc_pin_crossbar.sv */
// priority pin crossbar for the seven-pin port 0
//
// Notes on behaviour
// (RQ1) grant only without higher priority competitor
// (RQ2) digital grant is all pins or none
// (RQ3) analog connects only selected channel pins
// (RQ4) comparator shares converter selects and slot
// (RQ5) analog enable leaves digital settings alone
// (RQ6) software disables digital buffers before analog
// (RQ7) analog conflicts resolved by priority
// (RQ8) oscillator requests analog or digital pins
// (RQ9) idle pins follow gpio data and direction
// (RQ10) reset leaves every pin a digital input
// (RQ11) input pin feeds both default consumers
// (RQ12) output pin driven by gpio AND txd
// (RQ13) slave data out only while selected
// (RQ14) fixed seven-level priority order
// (RQ15) flash spi only in programming mode
// (RQ16) clock select codes set oscillator pins
// (RQ17) granted signals get tabulated directions
// (RQ18) granted pins leave gpio control
// (RQ19) features written one pin at a time; here gpio_wr_in writes the whole port
// (RQ20) grants recomputed combinationally
`timescale 1ns/1ps
module ppc_pin_crossbar
    import ppc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       srst_in,
    // pins (four signals each)
    input  wire logic [6:0] pin_in,
    output logic      [6:0] pin_out,
    output logic      [6:0] pin_oe_out,
    output logic      [6:0] pin_ana_out,
    // gpio registers
    input  wire logic [6:0] port_data_reg_in,
    input  wire logic [6:0] port_direction_reg_in,
    input  wire logic       gpio_wr_in,
    output logic      [6:0] port_pin_data_out,
    // peripheral enables
    input  wire logic       mspi_en_in,
    input  wire logic       sspi_en_in,
    input  wire logic       dbg_en_in,
    input  wire logic       twi_en_in,
    input  wire logic       pwm_en_in,
    input  wire logic       converter_en_in,
    input  wire logic       comparator_en_in,
    input  wire logic       programming_mode_input_in,
    input  wire logic [2:0] low_freq_clock_select_in,
    input  wire logic [3:0] converter_channel_select_in,
    input  wire logic [1:0] converter_reference_select_in,
    // peripheral outputs
    input  wire logic       master_spi_clock_out_in,
    input  wire logic       master_spi_data_out_in,
    input  wire logic       slave_spi_data_out_in,
    input  wire logic       dbg_tdo_in,
    input  wire logic       twi_sda_out_in,
    input  wire logic       twi_scl_out_in,
    input  wire logic       pwm0_in,
    input  wire logic       pwm1_in,
    input  wire logic       uart_txd_in,
    // peripheral inputs
    output logic            master_spi_data_in_out,
    output logic            slave_spi_clk_out,
    output logic            slave_spi_data_in_out,
    output logic            slave_spi_csn_n_out,
    output logic            dbg_tck_out,
    output logic            dbg_tms_out,
    output logic            dbg_tdi_out,
    output logic            two_wire_data_line_out,
    output logic            two_wire_clock_line_out,
    output logic            uart_rxd_out,
    output logic            timer0_in_out,
    output logic            ext_interrupt_zero_out,
    output logic            ext_interrupt_one_out,
    output logic            low_freq_clock_out,
    // status
    output logic      [7:0] owner_out,
    output logic            grant_mspi_out,
    output logic            grant_sspi_out,
    output logic            grant_dbg_out,
    output logic            grant_twi_out,
    output logic            grant_pwm_out,
    output logic            osc_analog_out
);

    ////////////////////////////////////////////////////////////////////////////
    // pin masks per block
    function automatic logic [6:0] ppc_bit(input int idx);
        ppc_bit = 7'(1) << idx;
    endfunction : ppc_bit

    // channel select to pin, only channels 0..6 exist on this port
    function automatic logic [6:0] ppc_chan(input logic [3:0] sel);
        ppc_chan = (sel < 4'h7) ? (7'h01 << sel) : 7'h00;
    endfunction : ppc_chan

    // pins claimed by each digital block, bit n is pin n of port 0
    // debug takes the sck, mosi and miso pins and drives tdo on the txd pin
    localparam logic [6:0] MASK_MSPI = 7'h1c;
    localparam logic [6:0] MASK_SSPI = 7'h3c;
    localparam logic [6:0] MASK_DBG  = 7'h3c;
    localparam logic [6:0] MASK_TWI  = 7'h60;
    localparam logic [6:0] MASK_PWM  = 7'h48;

    ////////////////////////////////////////////////////////////////////////////
    // gpio registers, reset to all inputs
    logic [6:0] gpio_dir_q;
    logic [6:0] gpio_dir_d;
    logic [6:0] gpio_data_q;
    logic [6:0] gpio_data_d;
    logic [6:0] pin_data_q;

    assign gpio_dir_d  = gpio_wr_in ? port_direction_reg_in : gpio_dir_q;
    assign gpio_data_d = gpio_wr_in ? port_data_reg_in : gpio_data_q;

    // register updates
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            gpio_dir_q  <= PPC_DIR_RST; // RQ10
            gpio_data_q <= PPC_DATA_RST;
            pin_data_q  <= 7'h00;
        end else begin
            gpio_dir_q  <= gpio_dir_d;
            gpio_data_q <= gpio_data_d;
            pin_data_q  <= pin_in;
        end
    end
    assign port_pin_data_out = pin_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator request from clock select
    wire osc_xtal = (low_freq_clock_select_in == PPC_LF_CRYSTAL); // RQ16
    wire osc_ana  = (low_freq_clock_select_in == PPC_LF_ANA_CLK); // RQ16
    wire osc_dig  = (low_freq_clock_select_in == PPC_LF_DIG_CLK); // RQ8
    wire [6:0] osc_ana_mask = osc_xtal ? 7'h03 : (osc_ana ? 7'h02 : 7'h00);
    wire [6:0] osc_dig_mask = osc_dig ? ppc_bit(PPC_PIN_P01) : 7'h00;
    assign osc_analog_out = osc_xtal | osc_ana;

    // slave spi also stands for flash spi in programming mode
    wire sspi_req = sspi_en_in | programming_mode_input_in; // RQ15

    ////////////////////////////////////////////////////////////////////////////
    // all-or-none grants by fixed priority, combinational
    // each stage adds the pins of a granted block, so a lower block
    // sees every pin already claimed above it
    wire [6:0] used0 = osc_dig_mask; // RQ14
    wire g_mspi = mspi_en_in && ((MASK_MSPI & used0) == 7'h00); // RQ1 RQ2 RQ20
    wire [6:0] used1 = used0 | (g_mspi ? MASK_MSPI : 7'h00);
    wire g_sspi = sspi_req && ((MASK_SSPI & used1) == 7'h00) && !mspi_en_in; // RQ1
    wire [6:0] used2 = used1 | (g_sspi ? MASK_SSPI : 7'h00);
    wire blk3 = mspi_en_in | sspi_req;
    wire g_dbg = dbg_en_in && ((MASK_DBG & used2) == 7'h00) && !blk3; // RQ2
    wire [6:0] used3 = used2 | (g_dbg ? MASK_DBG : 7'h00);
    wire g_twi = twi_en_in && ((MASK_TWI & used3) == 7'h00) && !(blk3 | dbg_en_in); // RQ1
    wire [6:0] used4 = used3 | (g_twi ? MASK_TWI : 7'h00);
    wire g_pwm = pwm_en_in && ((MASK_PWM & used4) == 7'h00)
                 && !(blk3 | dbg_en_in | twi_en_in); // RQ14
    wire [6:0] dig_mask = used4 | (g_pwm ? MASK_PWM : 7'h00);

    assign grant_mspi_out = g_mspi;
    assign grant_sspi_out = g_sspi;
    assign grant_dbg_out  = g_dbg;
    assign grant_twi_out  = g_twi;
    assign grant_pwm_out  = g_pwm;

    ////////////////////////////////////////////////////////////////////////////
    // analog connections: oscillator beats converter/comparator
    wire       ana_on   = converter_en_in | comparator_en_in; // RQ4
    wire [6:0] ref_mask = (converter_reference_select_in != 2'h0)
                          ? ppc_chan({2'h0, converter_reference_select_in}) : 7'h00;
    wire [6:0] conv_req = ana_on ? (ppc_chan(converter_channel_select_in) | ref_mask)
                          : 7'h00; // RQ3
    wire [6:0] conv_mask = conv_req & ~osc_ana_mask; // RQ7
    // analog switch does not alter digital drive
    assign pin_ana_out = osc_ana_mask | conv_mask; // RQ5

    ////////////////////////////////////////////////////////////////////////////
    // per-pin output value and enable
    // select is taken straight from the pin so the driver lets go
    // in the same cycle as the master deselects
    wire csn_active = g_sspi && !pin_in[PPC_PIN_TXD];
    logic [6:0] per_o;
    logic [6:0] per_oe;
    always_comb begin
        per_o  = 7'h00;
        per_oe = 7'h00;
        if (g_mspi) begin
            per_o[PPC_PIN_SCK]   = master_spi_clock_out_in; // RQ17
            per_oe[PPC_PIN_SCK]  = 1'b1;
            per_o[PPC_PIN_MOSI]  = master_spi_data_out_in;
            per_oe[PPC_PIN_MOSI] = 1'b1;
        end
        if (g_sspi) begin
            per_o[PPC_PIN_MISO]  = slave_spi_data_out_in;
            per_oe[PPC_PIN_MISO] = csn_active; // RQ13
        end
        if (g_dbg) begin
            per_o[PPC_PIN_TXD]  = dbg_tdo_in;
            per_oe[PPC_PIN_TXD] = 1'b1;
        end
        if (g_twi) begin
            // open drain: drive low only
            per_o[PPC_PIN_RXD]  = 1'b0;
            per_oe[PPC_PIN_RXD] = !twi_sda_out_in; // RQ17
            per_o[PPC_PIN_TXD]  = 1'b0;
            per_oe[PPC_PIN_TXD] = !twi_scl_out_in;
        end
        if (g_pwm) begin
            per_o[PPC_PIN_MOSI]  = pwm0_in;
            per_oe[PPC_PIN_MOSI] = 1'b1;
            per_o[PPC_PIN_RXD]   = pwm1_in;
            per_oe[PPC_PIN_RXD]  = 1'b1;
        end
    end

    // default gpio drive, txd ANDed on the txd and rxd pins
    // uart lines idle high, so the and gate passes gpio data when idle
    logic [6:0] gpio_o;
    always_comb begin
        gpio_o = gpio_data_q; // RQ9
        gpio_o[PPC_PIN_TXD] = gpio_data_q[PPC_PIN_TXD] & uart_txd_in; // RQ12
        gpio_o[PPC_PIN_RXD] = gpio_data_q[PPC_PIN_RXD] & uart_txd_in; // RQ12
    end

    // owned pins leave gpio control
    assign pin_out    = (dig_mask & per_o) | (~dig_mask & gpio_o); // RQ18
    assign pin_oe_out = (dig_mask & per_oe) | (~dig_mask & gpio_dir_q); // RQ9 RQ18

    ////////////////////////////////////////////////////////////////////////////
    // inputs to peripherals
    assign master_spi_data_in_out  = g_mspi ? pin_in[PPC_PIN_MISO] : 1'b0;
    assign slave_spi_clk_out       = g_sspi ? pin_in[PPC_PIN_SCK]  : 1'b0;
    assign slave_spi_data_in_out   = g_sspi ? pin_in[PPC_PIN_MOSI] : 1'b0;
    assign slave_spi_csn_n_out     = g_sspi ? pin_in[PPC_PIN_TXD]  : 1'b1;
    assign dbg_tck_out             = g_dbg  ? pin_in[PPC_PIN_SCK]  : 1'b0;
    assign dbg_tms_out             = g_dbg  ? pin_in[PPC_PIN_MOSI] : 1'b0;
    assign dbg_tdi_out             = g_dbg  ? pin_in[PPC_PIN_MISO] : 1'b0;
    assign two_wire_data_line_out  = g_twi  ? pin_in[PPC_PIN_RXD]  : 1'b1;
    assign two_wire_clock_line_out = g_twi  ? pin_in[PPC_PIN_TXD]  : 1'b1;
    assign low_freq_clock_out      = osc_dig ? pin_in[PPC_PIN_P01] : 1'b0;
    // second default consumers of input pins
    // a driven or claimed pin never feeds a second default consumer
    wire [6:0] idle_in = ~dig_mask & ~gpio_dir_q & pin_in; // RQ11
    assign uart_rxd_out           = ~dig_mask[PPC_PIN_RXD] ? idle_in[PPC_PIN_RXD] : 1'b1;
    assign timer0_in_out          = idle_in[PPC_PIN_MISO];
    assign ext_interrupt_zero_out = idle_in[PPC_PIN_P00]; // RQ11
    assign ext_interrupt_one_out  = idle_in[PPC_PIN_SCK];

    ////////////////////////////////////////////////////////////////////////////
    // owner status for pin 3 (most contended)
    // a pin-3 view is enough to see most priority levels contend
    ppc_owner_e own3;
    assign own3 = g_mspi ? PPC_OWN_MSPI : g_sspi ? PPC_OWN_SSPI : g_dbg ? PPC_OWN_DBG
                : g_pwm ? PPC_OWN_PWM : conv_mask[PPC_PIN_MOSI] ? PPC_OWN_ANA : PPC_OWN_GPIO;
    assign owner_out = own3;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_grant_all_none: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ2
        g_twi |-> pin_oe_out[PPC_PIN_RXD] == !twi_sda_out_in)
        else $error("twi grant not whole");
    a_prio_mspi_wins: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ1
        mspi_en_in && !osc_dig |-> !g_sspi && !g_dbg)
        else $error("lower priority granted over spi master");
    a_prio_chain: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ14
        (g_pwm |-> !twi_en_in && !dbg_en_in) and (g_twi |-> !dbg_en_in))
        else $error("priority order broken");
    a_miso_csn_gate: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ13
        pin_oe_out[PPC_PIN_MISO] && g_sspi |-> !pin_in[PPC_PIN_TXD])
        else $error("slave data out without select");
    a_ana_select: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ3
        !ana_on |-> (pin_ana_out & ~osc_ana_mask) == 7'h00)
        else $error("analog pin without request");
    a_ana_osc_prio: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ7
        osc_xtal |-> conv_mask[1:0] == 2'b00)
        else $error("converter took oscillator pin");
    a_reset_inputs: assert property (@(posedge ref_clk_in) // RQ10
        $past(srst_in) && !g_mspi && !g_sspi && !g_dbg && !g_twi && !g_pwm && !osc_dig
        |-> pin_oe_out == 7'h00)
        else $error("pin driven after reset");
    a_txd_and_gate: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ12
        !dig_mask[PPC_PIN_TXD] && !uart_txd_in |-> !pin_out[PPC_PIN_TXD])
        else $error("txd not anded");
    a_gpio_follow: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ9
        gpio_wr_in && dig_mask == 7'h00 ##1 dig_mask == 7'h00
        |-> pin_oe_out == $past(port_direction_reg_in))
        else $error("gpio direction not applied");
    // digital grants take their whole pin set in priority order
    a_dbg_whole: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ2
        g_dbg |-> pin_oe_out[PPC_PIN_TXD] && !pin_oe_out[PPC_PIN_SCK])
        else $error("debug grant not whole");
    a_sspi_prio: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ14
        g_sspi |-> !mspi_en_in)
        else $error("slave spi over spi master");
    a_dbg_prio: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ1
        g_dbg |-> !mspi_en_in && !sspi_req)
        else $error("debug over spi");
    a_flash_programming_mode_input: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ15
        programming_mode_input_in && !mspi_en_in |-> g_sspi)
        else $error("flash spi not granted");
    a_mspi_pins: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ17
        g_mspi |-> pin_oe_out[PPC_PIN_SCK] && !pin_oe_out[PPC_PIN_MISO])
        else $error("spi master directions wrong");
    a_mspi_drive: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ18
        g_mspi |-> pin_out[PPC_PIN_MOSI] == master_spi_data_out_in)
        else $error("spi master pin still gpio");
    a_pwm_drive: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ17
        g_pwm |-> pin_out[PPC_PIN_RXD] == pwm1_in)
        else $error("pwm pin not driven");
    a_twi_open: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ17
        g_twi |-> !pin_out[PPC_PIN_TXD] && !pin_out[PPC_PIN_RXD])
        else $error("two-wire drove high");
    a_csn_idle: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ13
        !g_sspi |-> slave_spi_csn_n_out)
        else $error("select active without grant");
    // default and analog connections
    a_ana_keeps_dig: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ5
        ana_on && dig_mask == 7'h00 |-> pin_oe_out == gpio_dir_q)
        else $error("analog changed digital direction");
    a_idle_rxd: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ11
        !dig_mask[PPC_PIN_RXD] && !gpio_dir_q[PPC_PIN_RXD] |-> uart_rxd_out == pin_in[PPC_PIN_RXD])
        else $error("rxd not fed from pin");
    a_ana_chan: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ3
        ana_on && converter_channel_select_in == 4'h7 && converter_reference_select_in == 2'h0
        |-> conv_mask == 7'h00)
        else $error("analog pin without channel");
    // oscillator pin use
    a_lf_clock: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ8
        osc_dig |-> low_freq_clock_out == pin_in[PPC_PIN_P01])
        else $error("digital clock not routed");
    a_osc_ana_pin: assert property (@(posedge ref_clk_in) disable iff (srst_in) // RQ16
        osc_ana |-> pin_ana_out[PPC_PIN_P01])
        else $error("analog clock pin not connected");
    c_mspi_grant: cover property (@(posedge ref_clk_in) g_mspi);
    c_sspi_denied: cover property (@(posedge ref_clk_in) sspi_en_in && !g_sspi);
    c_twi_grant: cover property (@(posedge ref_clk_in) g_twi);
    c_ana_conn: cover property (@(posedge ref_clk_in) conv_mask != 7'h00);
    c_pwm_grant: cover property (@(posedge ref_clk_in) g_pwm);

endmodule : ppc_pin_crossbar

/* ppc_pkg.sv */
// package for the priority pin crossbar: pin indices, codes and reset values
package ppc_pkg;
    localparam int          PPC_NPINS       = 7;
    // low-frequency clock select codes
    localparam logic [2:0]  PPC_LF_CRYSTAL  = 3'h0;
    localparam logic [2:0]  PPC_LF_ANA_CLK  = 3'h3;
    localparam logic [2:0]  PPC_LF_DIG_CLK  = 3'h4;
    // pin indices within port 0
    localparam int          PPC_PIN_P00     = 0;
    localparam int          PPC_PIN_P01     = 1;
    localparam int          PPC_PIN_SCK     = 2;
    localparam int          PPC_PIN_MOSI    = 3;
    localparam int          PPC_PIN_MISO    = 4;
    localparam int          PPC_PIN_TXD     = 5;
    localparam int          PPC_PIN_RXD     = 6;
    // reset values: all pins digital inputs
    localparam logic [6:0]  PPC_DIR_RST     = 7'h00;
    localparam logic [6:0]  PPC_DATA_RST    = 7'h00;
    // owner codes, one-hot per priority slot, gpio first, then highest to lowest
    typedef enum logic [7:0] {
        PPC_OWN_GPIO  = 8'h01,
        PPC_OWN_OSC   = 8'h02,
        PPC_OWN_MSPI  = 8'h04,
        PPC_OWN_SSPI  = 8'h08,
        PPC_OWN_DBG   = 8'h10,
        PPC_OWN_TWI   = 8'h20,
        PPC_OWN_PWM   = 8'h40,
        PPC_OWN_ANA   = 8'h80
    } ppc_owner_e;
endpackage : ppc_pkg

/* ppc_testbench.sv */
// testbench for the priority pin crossbar: random configurations and corner cases
`timescale 1ns/1ps
module testbench
    import ppc_pkg::*;
;
    logic       clk, srst, wr, mspi, sspi, dbg, twi, pwm, conv, comp, pgm;
    logic [6:0] pin_in, dat, dir, edat, edir, pprev;
    logic [2:0] lfsel;
    logic [3:0] chsel;
    logic [1:0] refsel;
    logic [7:0] en;
    logic [7:0] ctab [8] = '{8'h03, 8'h84, 8'h0c, 8'h18, 8'h30, 8'h80, 8'h7f, 8'h00};
    logic [2:0] ltab [3] = '{PPC_LF_CRYSTAL, PPC_LF_ANA_CLK, PPC_LF_DIG_CLK};
    wire  [6:0] pout, poe, pana, ppd;
    wire  [7:0] own;
    wire  [8:0] per;
    wire        misi, sclk, ssdi, scsn, rxd, t0, i0, i1, lfc, gm, gs, gd, gt, gp, oa;
    wire        tck, tms, tdi, tsda, tscl;
    int         n_fail, n_tests, cyc;

    ////////////////////////////////////////////////////////////////////////////
    // far side and the crossbar
    ppc_periph_model i_ppc_periph_model (.ref_clk_in(clk), .srst_in(srst), .periph_out(per));
    ppc_pin_crossbar i_ppc_pin_crossbar (
        .ref_clk_in(clk), .srst_in(srst), .pin_in(pin_in), .pin_out(pout),
        .pin_oe_out(poe), .pin_ana_out(pana), .port_data_reg_in(dat),
        .port_direction_reg_in(dir), .gpio_wr_in(wr), .port_pin_data_out(ppd),
        .mspi_en_in(mspi), .sspi_en_in(sspi), .dbg_en_in(dbg), .twi_en_in(twi),
        .pwm_en_in(pwm), .converter_en_in(conv), .comparator_en_in(comp),
        .programming_mode_input_in(pgm), .low_freq_clock_select_in(lfsel),
        .converter_channel_select_in(chsel), .converter_reference_select_in(refsel),
        .master_spi_clock_out_in(per[0]), .master_spi_data_out_in(per[1]),
        .slave_spi_data_out_in(per[2]), .dbg_tdo_in(per[3]), .twi_sda_out_in(per[4]),
        .twi_scl_out_in(per[5]), .pwm0_in(per[6]), .pwm1_in(per[7]), .uart_txd_in(per[8]),
        .master_spi_data_in_out(misi), .slave_spi_clk_out(sclk),
        .slave_spi_data_in_out(ssdi), .slave_spi_csn_n_out(scsn), .dbg_tck_out(tck),
        .dbg_tms_out(tms), .dbg_tdi_out(tdi), .two_wire_data_line_out(tsda),
        .two_wire_clock_line_out(tscl), .uart_rxd_out(rxd), .timer0_in_out(t0),
        .ext_interrupt_zero_out(i0), .ext_interrupt_one_out(i1), .low_freq_clock_out(lfc),
        .owner_out(own), .grant_mspi_out(gm), .grant_sspi_out(gs), .grant_dbg_out(gd),
        .grant_twi_out(gt), .grant_pwm_out(gp), .osc_analog_out(oa));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_sim();
        end
    end

    // one comparison, counted and reported on mismatch
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic bit coin();
        return ($urandom % 4) == 0;
    endfunction : coin

    // expected outputs worked out from the current inputs
    task automatic check_all();
        logic       sreq, hi, em, es, ed, ep;
        logic [6:0] eo, ea;
        logic [7:0] ow;
        sreq = sspi | pgm;
        eo = edat & {per[8], per[8], 5'h1f};
        ea = (lfsel == PPC_LF_CRYSTAL) ? 7'h03 : (lfsel == PPC_LF_ANA_CLK) ? 7'h02 : 7'h00;
        if ((conv | comp) && chsel < 4'h7) ea[chsel[2:0]] = 1'b1;
        if ((conv | comp) && refsel != 2'h0) ea[refsel] = 1'b1;
        chk("analog", 8'(pana), 8'(ea));
        chk("osc_ana", 8'(oa), 8'(lfsel != PPC_LF_DIG_CLK));
        chk("pin_rd", 8'(ppd), 8'(pprev));
        if (lfsel == PPC_LF_DIG_CLK) begin
            chk("lf_clk", 8'(lfc), 8'(pin_in[1]));
            return;
        end
        em = mspi;
        es = sreq & !em;
        ed = dbg & !(em | sreq);
        hi = mspi | sreq | dbg | twi;
        ep = pwm & !hi;
        chk("g_mspi", 8'(gm), 8'(em));
        chk("g_sspi", 8'(gs), 8'(es));
        chk("g_dbg", 8'(gd), 8'(ed));
        chk("g_twi", 8'(gt), 8'(twi & !(mspi | sreq | dbg)));
        chk("g_pwm", 8'(gp), 8'(ep));
        ow = ep ? PPC_OWN_PWM : ed ? PPC_OWN_DBG : es ? PPC_OWN_SSPI : PPC_OWN_GPIO;
        if (em) ow = PPC_OWN_MSPI;
        if (!(conv | comp)) chk("owner", own, ow);
        if (!(hi | pwm)) begin
            chk("oe_dflt", 8'(poe), 8'(edir));
            chk("out_dflt", 8'(pout & edir), 8'(eo & edir));
            if (!edir[6]) chk("rxd", 8'(rxd), 8'(pin_in[6]));
            if (!edir[4]) chk("timer0", 8'(t0), 8'(pin_in[4]));
            if (!edir[0]) chk("int0", 8'(i0), 8'(pin_in[0]));
            if (!edir[2]) chk("int1", 8'(i1), 8'(pin_in[2]));
        end
        if (em) begin
            chk("mspi_oe", 8'(poe[4:2]), 8'h03);
            chk("mspi_out", 8'(pout[3:2]), 8'(per[1:0]));
            chk("mspi_in", 8'(misi), 8'(pin_in[4]));
        end
        if (es) begin
            chk("sdo_oe", 8'(poe[4]), 8'(!pin_in[5]));
            chk("sspi_in", 8'({sclk, ssdi, scsn}), 8'({pin_in[2], pin_in[3], pin_in[5]}));
            if (!pin_in[5]) chk("sdo", 8'(pout[4]), 8'(per[2]));
        end
        if (ed) begin
            chk("dbg_in", 8'({tck, tms, tdi}), 8'({pin_in[2], pin_in[3], pin_in[4]}));
            chk("dbg_out", 8'({poe[5], pout[5]}), 8'({1'b1, per[3]}));
        end
        if (twi & !(mspi | sreq | dbg)) begin
            chk("twi_in", 8'({tsda, tscl}), 8'(pin_in[6:5]));
            chk("twi_oe", 8'({poe[6], poe[5]}), 8'({!per[4], !per[5]}));
        end
        if (ep) begin
            chk("pwm_oe", 8'({poe[6], poe[3]}), 8'h03);
            chk("pwm_out", 8'({pout[6], pout[3]}), 8'(per[7:6]));
        end
    endtask : check_all

    // verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(2967));
        {clk, srst, wr, pin_in, dat, dir, edat, edir, pprev} = '0;
        {pgm, comp, conv, pwm, twi, dbg, sspi, mspi, chsel, refsel} = '0;
        lfsel = PPC_LF_ANA_CLK;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("oe_reset", 8'(poe), 8'h00);
        $display("test reset done");
        for (int i = 0; i < 600; i++) begin
            @(posedge clk);
            if (wr) begin
                edat = dat;
                edir = dir;
            end
            pprev = pin_in;
            en = {coin() & coin(), coin(), coin(), coin(), coin(), coin(), coin(), coin()};
            if (i < 8) en = ctab[i];
            {pgm, comp, conv, pwm, twi, dbg, sspi, mspi} <= en;
            pin_in <= 7'($urandom);
            dat    <= 7'($urandom);
            dir    <= 7'($urandom);
            // whole-port direction writes; pin features are not modelled
            wr     <= coin();
            refsel <= 2'($urandom);
            chsel  <= (i < 8) ? 4'(i) : 4'($urandom % 9);
            lfsel  <= (i < 8) ? PPC_LF_ANA_CLK : ltab[$urandom % 3];
            @(negedge clk);
            check_all();
        end
        $display("test random done");
        @(posedge clk);
        srst <= 1'b1;
        wr   <= 1'b0;
        {pgm, comp, conv, pwm, twi, dbg, sspi, mspi} <= 8'h00;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("oe_rerst", 8'(poe), 8'h00);
        $display("test second reset done");
        end_sim();
    end
endmodule : testbench
